// file: clock_power_consts.svh
// Register offsets, field positions and reset values of the clock and power manager
`ifndef CLOCK_POWER_CONSTS_SVH
`define CLOCK_POWER_CONSTS_SVH

`define ADDR_W            4
`define REG_SYNTH_CTRL    4'h0
`define REG_POWER_CTRL    4'h1
`define REG_AWAIT_CTRL    4'h2
`define REG_STATUS        4'h3

`define SYNTH_PWR_BIT     15
`define SYNTH_SEL_BIT     14
`define SYNTH_N_HI        7
`define SYNTH_N_LO        5
`define SYNTH_M_HI        4
`define SYNTH_M_LO        0
`define SYNTH_N_ONE       3'h7
`define SYNTH_RESET       16'h0000

`define PWR_OSC_OFF_BIT   15
`define PWR_SLOW_BIT      14
`define PWR_STOP_BIT      13
`define PWR_WAKE0_BIT     9
`define PWR_WAKE1_BIT     8
`define PWR_SER1_BIT      7
`define PWR_SER2_BIT      6
`define PWR_HOST_BIT      5
`define PWR_TMR_BIT       4
`define PWR_MASK          16'hE3F0
`define PWR_RESET         16'h0000

`define AWAIT_BIT         15

`define CNT_W             6
`define TICK_GAP          2'h2
`define PIN_COUNT         8
`define PIN_EXT_CLK       0
`define PIN_SYNTH_CLK     1
`define PIN_SYNTH_LOCK    2
`define PIN_RING_CLK      3
`define PIN_IRQ0          4
`define PIN_IRQ1          5
`define PIN_RESET_N       6
`define PIN_STOP_N        7
`define PIN_RESET_VAL     8'hC0

`endif

// file: clock_power_pkg.sv
// Types shared by the clock and power manager
package clock_power_pkg;
  typedef enum logic [1:0] {SRC_EXT, TO_SYNTH, SRC_SYNTH, TO_EXT} src_state_t;
endpackage

// file: dsp_clock_power_manager.sv
// Clock source selection, clock gating and power management of the processor
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`include "clock_power_consts.svh"

module dsp_clock_power_manager
  import clock_power_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [`ADDR_W-1:0]    addr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [15:0]           rdata,
  input  wire logic                  ext_in_clk,
  input  wire logic                  synth_clk,
  input  wire logic                  synth_locked,
  input  wire logic                  ring_osc_clk,
  input  wire logic                  irq_pin0,
  input  wire logic                  irq_pin1,
  input  wire logic                  reset_pin_n,
  input  wire logic                  stop_pin_n,
  input  wire logic                  timer_own_disable,
  output logic                       core_clk_en,
  output logic                       serial_unit1_clk_en,
  output logic                       serial_unit2_clk_en,
  output logic                       host_port_clk_en,
  output logic                       tmr_clk_en,
  output logic                       synth_power_on,
  output logic                       synth_active,
  output logic                       ring_osc_power_on,
  output logic                       osc_input_powered
);

  // Divider decode
  function automatic logic [`CNT_W-1:0] n_count(input logic [2:0] nbits);
    if (nbits == `SYNTH_N_ONE)
      n_count = `CNT_W'(1);
    else
      n_count = `CNT_W'(nbits) + `CNT_W'(2);
  endfunction

  function automatic logic [`CNT_W-1:0] m_count(input logic [4:0] mbits);
    m_count = `CNT_W'(mbits) + `CNT_W'(2);
  endfunction

  // Pin synchronisers: a change counts once stages two and three agree
  logic [`PIN_COUNT-1:0] s1_r, s2_r, s3_r, pin_r;
  logic [`PIN_COUNT-1:0] s1_nxt, s2_nxt, s3_nxt, pin_nxt;

  always_comb
  begin
    s1_nxt  = {stop_pin_n, reset_pin_n, irq_pin1, irq_pin0,
               ring_osc_clk, synth_locked, synth_clk, ext_in_clk};
    s2_nxt  = s1_r;
    s3_nxt  = s2_r;
    pin_nxt = pin_r;
    for (int i = 0; i < `PIN_COUNT; i++)
    begin
      if (s2_r[i] == s3_r[i])
        pin_nxt[i] = s3_r[i];
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s1_r  <= `PIN_RESET_VAL;
      s2_r  <= `PIN_RESET_VAL;
      s3_r  <= `PIN_RESET_VAL;
      pin_r <= `PIN_RESET_VAL;
    end
    else
    begin
      s1_r  <= s1_nxt;
      s2_r  <= s2_nxt;
      s3_r  <= s3_nxt;
      pin_r <= pin_nxt;
    end
  end

  // Source ticks are rising edges of the filtered source clocks
  logic ext_tick, synth_tick, ring_tick, reset_pin_low, stop_pin_low;
  logic irq0_hi, irq1_hi;

  assign ext_tick      = pin_nxt[`PIN_EXT_CLK] & ~pin_r[`PIN_EXT_CLK];
  assign synth_tick    = pin_nxt[`PIN_SYNTH_CLK] & ~pin_r[`PIN_SYNTH_CLK];
  assign ring_tick     = pin_nxt[`PIN_RING_CLK] & ~pin_r[`PIN_RING_CLK];
  assign reset_pin_low = ~pin_r[`PIN_RESET_N];
  assign stop_pin_low  = ~pin_r[`PIN_STOP_N];
  assign irq0_hi       = pin_r[`PIN_IRQ0];
  assign irq1_hi       = pin_r[`PIN_IRQ1];

  // Registers and switching state
  logic [15:0]          synth_ctrl_r, synth_ctrl_nxt;
  logic [15:0]          power_ctrl_r, power_ctrl_nxt;
  logic                 await_r, await_nxt;
  logic                 lock_r, lock_nxt;
  src_state_t           src_r, src_nxt;
  logic [`CNT_W-1:0]    cnt_r, cnt_nxt;
  logic                 slow_active_r, slow_active_nxt;
  logic                 deep_sleep_r, deep_sleep_nxt;
  logic [15:0]          rdata_nxt;
  logic                 core_en_nxt, ser1_nxt, ser2_nxt, host_nxt, tmr_nxt;
  logic                 ring_pwr_nxt;

  logic                 on_synth, src_tick, clock_alive, deep_sleep, wr_synth, wr_power;
  logic [`CNT_W-1:0]    n_val, m_val;

  assign n_val    = n_count(synth_ctrl_r[`SYNTH_N_HI:`SYNTH_N_LO]);
  assign m_val    = m_count(synth_ctrl_r[`SYNTH_M_HI:`SYNTH_M_LO]);
  assign wr_synth = wr && (addr == `REG_SYNTH_CTRL);
  assign wr_power = wr && (addr == `REG_POWER_CTRL);

  // The synthesizer pin already carries half the oscillator rate
  assign on_synth = (src_r == SRC_SYNTH) || (src_r == TO_EXT);
  // Tick of the source in use. The source may change in any cycle, so two ticks
  // of different clocks can fall close together; tick_ok below guards that
  always_comb
  begin
    if (slow_active_r)
      src_tick = ring_tick;
    else if (on_synth)
      src_tick = synth_tick;
    else
      src_tick = ext_tick;
  end

  // Deep sleep: stop bit, stop pin or dead input circuit off the ring oscillator
  assign deep_sleep  = power_ctrl_r[`PWR_STOP_BIT] | stop_pin_low
                     | (power_ctrl_r[`PWR_OSC_OFF_BIT] & ~slow_active_r);
  assign clock_alive = ~deep_sleep;

  // Guard after every passed tick: a swap of sources may place a new tick next
  // to the last old one, and that short period must never reach a load
  // Dropping such a tick only stretches one period, which the loads tolerate
  logic [1:0]           gap_r, gap_nxt;
  logic                 tick_ok;

  assign tick_ok = src_tick & (gap_r == 2'h0);

  always_comb
  begin
    gap_nxt = gap_r;
    if (tick_ok)
      gap_nxt = `TICK_GAP;
    else if (gap_r != 2'h0)
      gap_nxt = gap_r - 2'h1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      gap_r <= 2'h0;
    else
      gap_r <= gap_nxt;
  end

  // Register and power control state
  always_comb
  begin
    synth_ctrl_nxt  = synth_ctrl_r;
    power_ctrl_nxt  = power_ctrl_r;
    await_nxt       = await_r;
    lock_nxt        = lock_r;
    slow_active_nxt = power_ctrl_r[`PWR_SLOW_BIT];
    deep_sleep_nxt  = deep_sleep;
    if (wr_synth)
    begin
      synth_ctrl_nxt = wdata;
      lock_nxt       = 1'b0;
    end
    // Lock detection stops once the flag is set; a lock beats a same-cycle clear
    if (!lock_r && synth_ctrl_r[`SYNTH_PWR_BIT] && pin_r[`PIN_SYNTH_LOCK])
      lock_nxt = 1'b1;
    if (wr_power)
      power_ctrl_nxt = wdata & `PWR_MASK;
    // Wakes win over a same-cycle software write of the stop bit
    if ((irq0_hi && power_ctrl_r[`PWR_WAKE0_BIT])
        || (irq1_hi && power_ctrl_r[`PWR_WAKE1_BIT]))
      power_ctrl_nxt[`PWR_STOP_BIT] = 1'b0;
    // Reset pin only undoes the stop and osc-off bits; all other state is kept
    if (reset_pin_low)
    begin
      power_ctrl_nxt[`PWR_STOP_BIT]    = 1'b0;
      power_ctrl_nxt[`PWR_OSC_OFF_BIT] = 1'b0;
    end
    if (wr && (addr == `REG_AWAIT_CTRL) && clock_alive)
      await_nxt = wdata[`AWAIT_BIT];
    // Any interrupt ends standby; it wins over a write in the same cycle
    if (irq0_hi || irq1_hi)
      await_nxt = 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      synth_ctrl_r  <= `SYNTH_RESET;
      power_ctrl_r  <= `PWR_RESET;
      await_r       <= 1'b0;
      lock_r        <= 1'b0;
      slow_active_r <= 1'b0;
      deep_sleep_r  <= 1'b0;
    end
    else
    begin
      synth_ctrl_r  <= synth_ctrl_nxt;
      power_ctrl_r  <= power_ctrl_nxt;
      await_r       <= await_nxt;
      lock_r        <= lock_nxt;
      slow_active_r <= slow_active_nxt;
      deep_sleep_r  <= deep_sleep_nxt;
    end
  end

  // Input clock / synthesizer switch. The count runs on old-source ticks, so
  // the core keeps its old rate until the swap
  always_comb
  begin
    src_nxt = src_r;
    cnt_nxt = cnt_r;
    case (src_r)
      SRC_EXT:
      begin
        if (synth_ctrl_r[`SYNTH_SEL_BIT])
        begin
          src_nxt = TO_SYNTH;
          cnt_nxt = n_val + `CNT_W'(1);
        end
      end
      TO_SYNTH:
      begin
        if (!synth_ctrl_r[`SYNTH_SEL_BIT])
          src_nxt = SRC_EXT;
        else if (ext_tick)
        begin
          if (cnt_r <= `CNT_W'(1))
            src_nxt = SRC_SYNTH;
          else
            cnt_nxt = cnt_r - `CNT_W'(1);
        end
      end
      SRC_SYNTH:
      begin
        if (!synth_ctrl_r[`SYNTH_SEL_BIT])
        begin
          src_nxt = TO_EXT;
          cnt_nxt = `CNT_W'(m_val / n_val) + `CNT_W'(1);
        end
      end
      TO_EXT:
      begin
        if (synth_ctrl_r[`SYNTH_SEL_BIT])
          src_nxt = SRC_SYNTH;
        else if (synth_tick || !synth_ctrl_r[`SYNTH_PWR_BIT])
        begin
          if (cnt_r <= `CNT_W'(1) || !synth_ctrl_r[`SYNTH_PWR_BIT])
            src_nxt = SRC_EXT;
          else
            cnt_nxt = cnt_r - `CNT_W'(1);
        end
      end
      default:
      begin
        src_nxt = SRC_EXT;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      src_r <= SRC_EXT;
      cnt_r <= '0;
    end
    else
    begin
      src_r <= src_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Clock gates and outputs; whole ticks pass or none do
  always_comb
  begin
    core_en_nxt  = tick_ok & ~deep_sleep & ~await_r;
    // Peripherals are stopped by deep sleep but keep running in standby
    ser1_nxt     = tick_ok & ~deep_sleep & ~power_ctrl_r[`PWR_SER1_BIT];
    ser2_nxt     = tick_ok & ~deep_sleep & ~power_ctrl_r[`PWR_SER2_BIT];
    host_nxt     = tick_ok & ~deep_sleep & ~power_ctrl_r[`PWR_HOST_BIT];
    tmr_nxt      = tick_ok & ~deep_sleep
                 & ~(power_ctrl_r[`PWR_TMR_BIT] | timer_own_disable);
    // Ring oscillator drops one cycle after the gate closed
    ring_pwr_nxt = power_ctrl_r[`PWR_SLOW_BIT] & ~(deep_sleep & deep_sleep_r);
    rdata_nxt    = 16'h0000;
    if (rd)
    begin
      case (addr)
        `REG_SYNTH_CTRL: rdata_nxt = synth_ctrl_r;
        `REG_POWER_CTRL: rdata_nxt = power_ctrl_r;
        `REG_AWAIT_CTRL: rdata_nxt = {await_r, 15'h0000};
        `REG_STATUS:     rdata_nxt = {11'h000, deep_sleep, clock_alive & ~await_r,
                                      slow_active_r, on_synth, lock_r};
        default:         rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rdata               <= 16'h0000;
      core_clk_en         <= 1'b0;
      serial_unit1_clk_en <= 1'b0;
      serial_unit2_clk_en <= 1'b0;
      host_port_clk_en    <= 1'b0;
      tmr_clk_en          <= 1'b0;
      synth_power_on      <= 1'b0;
      synth_active        <= 1'b0;
      ring_osc_power_on   <= 1'b0;
      osc_input_powered   <= 1'b1;
    end
    else
    begin
      rdata               <= rdata_nxt;
      core_clk_en         <= core_en_nxt;
      serial_unit1_clk_en <= ser1_nxt;
      serial_unit2_clk_en <= ser2_nxt;
      host_port_clk_en    <= host_nxt;
      tmr_clk_en          <= tmr_nxt;
      // Synthesizer power ignores stop and standby
      synth_power_on      <= synth_ctrl_r[`SYNTH_PWR_BIT];
      synth_active        <= on_synth;
      ring_osc_power_on   <= ring_pwr_nxt;
      osc_input_powered   <= ~power_ctrl_r[`PWR_OSC_OFF_BIT];
    end
  end

endmodule

// file: cpm_chk_sva.sv
// Port-level assertions for the clock and power manager
`include "clock_power_consts.svh"
module cpm_chk (
  input wire logic               clock,
  input wire logic               rst,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [15:0]        wdata,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [15:0]        rdata,
  input wire logic               stop_pin_n,
  input wire logic               timer_own_disable,
  input wire logic               core_clk_en,
  input wire logic               tmr_clk_en,
  input wire logic               synth_power_on,
  input wire logic               synth_active,
  input wire logic               ring_osc_power_on,
  input wire logic               osc_input_powered
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_rst_idle;
    $fell(rst) |-> !synth_power_on && !synth_active && osc_input_powered && !ring_osc_power_on;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
  property p_pwr_bit;
    wr && addr == `REG_SYNTH_CTRL |-> ##2 synth_power_on == $past(wdata[`SYNTH_PWR_BIT], 2);
  endproperty
  a_pwr_bit: assert property (p_pwr_bit) else $error("synth power does not follow bit 15");
  property p_sel_late;
    wr && addr == `REG_SYNTH_CTRL && wdata[`SYNTH_SEL_BIT] && !synth_active |=> !synth_active [*2];
  endproperty
  a_sel_late: assert property (p_sel_late) else $error("source switched at once");
  property p_core_pulse;
    core_clk_en |=> !core_clk_en [*2];
  endproperty
  a_core_pulse: assert property (p_core_pulse) else $error("core enable too dense");
  property p_stop_pin;
    !stop_pin_n [*7] |-> !core_clk_en;
  endproperty
  a_stop_pin: assert property (p_stop_pin) else $error("core clocked with stop pin low");
  property p_osc_off;
    (!osc_input_powered && !ring_osc_power_on) [*4] |-> !core_clk_en;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("core clocked with input off");
  property p_tmr_own;
    timer_own_disable [*2] |-> !tmr_clk_en;
  endproperty
  a_tmr_own: assert property (p_tmr_own) else $error("timer clocked while disabled");
  property p_synth_keep;
    !stop_pin_n && !$past(wr, 2) |-> $stable(synth_power_on);
  endproperty
  a_synth_keep: assert property (p_synth_keep) else $error("synth power moved in stop");
  property p_rd_idle;
    !$past(rd) |-> rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  c_to_synth: cover property ($rose(synth_active));
  c_to_ext: cover property ($fell(synth_active));
  c_stop: cover property (!stop_pin_n [*7]);
endmodule

bind dsp_clock_power_manager cpm_chk i_chk (.*);

// file: clk_src_model.sv
// Clock sources and lock detector at the far side of the manager
module clk_src_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic synth_power_on,
  input  wire logic ring_osc_power_on,
  input  wire logic osc_input_powered,
  output logic      ext_in_clk,
  output logic      synth_clk,
  output logic      ring_osc_clk,
  output logic      synth_locked
);
  timeunit 1ns;
  timeprecision 1ps;
  int ext_cnt, syn_cnt, ring_cnt, lock_cnt;
  // Unpowered sources stand still low rather than hold a stale phase
  always_ff @(posedge clock)
  begin
    ext_cnt <= (rst || ext_cnt == 3) ? 0 : ext_cnt + 1;
    syn_cnt <= (rst || syn_cnt == 2) ? 0 : syn_cnt + 1;
    ring_cnt <= (rst || ring_cnt == 4) ? 0 : ring_cnt + 1;
    lock_cnt <= (rst || !synth_power_on) ? 0 : lock_cnt + 1;
    // Held low in reset so that no source starts from an unknown phase
    ext_in_clk <= !rst && osc_input_powered && (ext_in_clk ^ (ext_cnt == 3));
    synth_clk <= !rst && synth_power_on && (synth_clk ^ (syn_cnt == 2));
    ring_osc_clk <= !rst && ring_osc_power_on && (ring_osc_clk ^ (ring_cnt == 4));
    synth_locked <= synth_power_on && lock_cnt > 40;
  end
endmodule

// file: tb_dsp_clock_power_manager.sv
// Self-checking bench for the clock and power manager
`include "clock_power_consts.svh"
module tb_dsp_clock_power_manager;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clock, rst, wr, rd, irq_pin0, irq_pin1, stop_pin_n, timer_own_disable;
  logic               reset_pin_n;
  logic [`ADDR_W-1:0] addr;
  logic [15:0]        wdata, rdata, v;
  logic               ext_in_clk, synth_clk, synth_locked, ring_osc_clk, core_clk_en;
  logic               serial_unit1_clk_en, serial_unit2_clk_en, host_port_clk_en, tmr_clk_en;
  logic               synth_power_on, synth_active, ring_osc_power_on, osc_input_powered;
  int                 fails = 0, checked = 0, c, p, t;
  dsp_clock_power_manager i_dut (.*);
  clk_src_model i_src (.*);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] m, e, input string nm);
    @(posedge clock);
    {addr, rd} <= {a, 1'b1};
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    v = rdata;
    chk(nm, e, v & m);
  endtask
  task automatic pulses(input int n);
    c = 0;
    p = 0;
    t = 0;
    // Skip the edge at which enables computed before the last write still show
    @(posedge clock);
    repeat (n)
    begin
      @(posedge clock);
      c += int'(core_clk_en);
      p += int'(serial_unit1_clk_en | serial_unit2_clk_en | host_port_clk_en);
      t += int'(tmr_clk_en);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #200us;
    fails++;
    wrap_up;
  end
  initial
  begin
    {rst, wr, rd, irq_pin0, irq_pin1, timer_own_disable, stop_pin_n, reset_pin_n} = 8'b10000011;
    {addr, wdata} = '0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd_chk(`REG_SYNTH_CTRL, 16'hFFFF, 16'h0000, "synth_ctrl");
    rd_chk(`REG_POWER_CTRL, 16'hFFFF, 16'h0000, "power_ctrl");
    rd_chk(4'hF, 16'hFFFF, 16'h0000, "unmapped");
    rd_chk(`REG_STATUS, 16'h001E, 16'h0008, "status");
    $display("reset test done");
    wr_reg(`REG_SYNTH_CTRL, 16'h2912);
    wr_reg(`REG_SYNTH_CTRL, 16'hA912);
    rd_chk(`REG_SYNTH_CTRL, 16'hFFFF, 16'hA912, "synth_ctrl");
    for (int i = 0; i < 30 && v[0] !== 1'b1; i++) rd_chk(`REG_STATUS, 16'h2, 16'h0, "poll");
    chk("lock", 16'h0001, v & 16'h0001);
    wr_reg(`REG_SYNTH_CTRL, 16'hE912);
    rd_chk(`REG_STATUS, 16'h0002, 16'h0000, "old_src");
    for (int i = 0; i < 80 && synth_active !== 1'b1; i++) @(posedge clock);
    chk("to_synth", 16'h0001, {15'h0, synth_active});
    wr_reg(`REG_SYNTH_CTRL, 16'hA912);
    repeat (50) @(posedge clock);
    chk("back_min", 16'h0001, {15'h0, synth_active});
    for (int i = 0; i < 250 && synth_active !== 1'b0; i++) @(posedge clock);
    chk("back_max", 16'h0000, {15'h0, synth_active});
    $display("synth test done");
    wr_reg(`REG_POWER_CTRL, 16'h00F0);
    pulses(40);
    chk("periph_off", 16'h0, 16'(p));
    chk("tmr_off", 16'h0, 16'(t));
    chk("core_on", 16'h1, {15'h0, c != 0});
    wr_reg(`REG_POWER_CTRL, 16'h0000);
    timer_own_disable <= 1'b1;
    pulses(40);
    chk("periph_on", 16'h1, {15'h0, p != 0});
    chk("tmr_own", 16'h0, 16'(t));
    timer_own_disable <= 1'b0;
    pulses(40);
    chk("tmr_on", 16'h1, {15'h0, t != 0});
    $display("peripheral test done");
    for (int i = 0; i < 2; i++)
    begin
      wr_reg(`REG_POWER_CTRL, i == 0 ? 16'h2200 : 16'h2100);
      pulses(30);
      chk("stopped", 16'h0, 16'(c));
      rd_chk(`REG_STATUS, 16'h0010, 16'h0010, "deep");
      {irq_pin1, irq_pin0} <= i == 0 ? 2'b01 : 2'b10;
      repeat (8) @(posedge clock);
      {irq_pin1, irq_pin0} <= 2'b00;
      rd_chk(`REG_POWER_CTRL, 16'h2000, 16'h0000, "stop_bit");
      pulses(30);
      chk("resumed", 16'h1, {15'h0, c != 0});
    end
    wr_reg(`REG_POWER_CTRL, 16'h2000);
    irq_pin0 <= 1'b1;
    repeat (8) @(posedge clock);
    irq_pin0 <= 1'b0;
    rd_chk(`REG_POWER_CTRL, 16'h2000, 16'h2000, "wake_masked");
    reset_pin_n <= 1'b0;
    repeat (8) @(posedge clock);
    reset_pin_n <= 1'b1;
    rd_chk(`REG_POWER_CTRL, 16'h2000, 16'h0000, "pin_reset");
    $display("wake test done");
    wr_reg(`REG_POWER_CTRL, 16'h8000);
    pulses(30);
    chk("osc_off", 16'h0, 16'(c));
    chk("osc_pwr", 16'h0, {15'h0, osc_input_powered});
    wr_reg(`REG_POWER_CTRL, 16'h4000);
    pulses(40);
    chk("ring_on", 16'h1, {15'h0, ring_osc_power_on});
    chk("slow_run", 16'h1, {15'h0, c != 0});
    wr_reg(`REG_POWER_CTRL, 16'h6200);
    pulses(12);
    chk("ring_down", 16'h0, {15'h0, ring_osc_power_on});
    irq_pin0 <= 1'b1;
    repeat (8) @(posedge clock);
    irq_pin0 <= 1'b0;
    wr_reg(`REG_POWER_CTRL, 16'h0000);
    pulses(12);
    chk("ring_idle", 16'h0, {15'h0, ring_osc_power_on});
    $display("slow test done");
    stop_pin_n <= 1'b0;
    repeat (8) @(posedge clock);
    pulses(20);
    chk("pin_stop0", 16'h0, 16'(c));
    wr_reg(`REG_AWAIT_CTRL, 16'h8000);
    stop_pin_n <= 1'b1;
    repeat (8) @(posedge clock);
    rd_chk(`REG_STATUS, 16'h0008, 16'h0008, "await_refused");
    wr_reg(`REG_AWAIT_CTRL, 16'h8000);
    rd_chk(`REG_STATUS, 16'h0008, 16'h0000, "standby");
    stop_pin_n <= 1'b0;
    pulses(20);
    chk("pin_stop", 16'h0, 16'(c));
    rd_chk(`REG_STATUS, 16'h0010, 16'h0010, "pin_deep");
    stop_pin_n <= 1'b1;
    repeat (8) @(posedge clock);
    rd_chk(`REG_STATUS, 16'h0018, 16'h0000, "back_standby");
    irq_pin1 <= 1'b1;
    repeat (8) @(posedge clock);
    irq_pin1 <= 1'b0;
    rd_chk(`REG_STATUS, 16'h0008, 16'h0008, "await_wake");
    $display("standby test done");
    wrap_up;
  end
endmodule
